//--- design/adc_readout_pkg.sv
// Constants, field layouts and carrier types for the dedicated channel readout
// Functional notes
// - Channel 0: battery voltage, unsigned ten-bit code
// - Current path runs only while enable set
// - Enable clear: channel 1 slots read zero
// - Sample voltage, current together; convert voltage first
// - Single mode channel 1: four voltage/current pairs
// - Multi mode: voltage slot 0, current slot 1
// - Current results are two's complement ten-bit
// - Channel 2: supply voltage, unsigned ten-bit code
// - Charger divider: one means five, zero ten
// - Results ten bits; readout uses first slot address
// - Single mode: all eight use addressed channel, except channel 1 (pairs)
package adc_readout_pkg;
	localparam int RES_W    = 10;
	localparam int SLOTS    = 8;
	localparam int IDX_W    = 3;
	localparam int CLK_HZ   = 10_000_000;
	localparam int TBASE_HZ = 32_768;
	localparam int TICK_CYC = CLK_HZ / TBASE_HZ;
	localparam int TICK_W   = 9;
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_RESULT = 8'h08;
	localparam int CTRL_START = 0;
	localparam int CTRL_MODE  = 1;
	localparam int CTRL_BEN   = 2;
	localparam int CTRL_DIV   = 3;
	localparam int CTRL_ADDR  = 4;
	localparam int STAT_BUSY  = 0;
	localparam int STAT_DONE  = 1;
	localparam logic [IDX_W-1:0] CH_VBAT = 3'h0;
	localparam logic [IDX_W-1:0] CH_IBAT = 3'h1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [RES_W-1:0] CODE_ZERO = 10'h000;
	localparam logic [RES_W-1:0] SIGN_BIT  = 10'h200;
	typedef struct packed {
		logic [IDX_W-1:0] first_slot_address;
		logic             charger_divider_select;
		logic             battery_current_enable;
		logic             channel_mode_select;
	} ctrl_t;
	localparam ctrl_t CTRL_RESET = '{first_slot_address: 3'h0, charger_divider_select: 1'b1,
		battery_current_enable: 1'b0, channel_mode_select: 1'b0};
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} seq_state_t;
endpackage : adc_readout_pkg

//--- design/result_coder.sv
// Turns a raw converter code into the stored result for one conversion
`timescale 1ns/1ps
module result_coder (
	input  wire logic [2:0] sel,
	input  wire logic       current_on,
	input  wire logic [9:0] raw,
	output logic      [9:0] coded
);
	// Core delivers bipolar inputs offset binary; flipping the top bit gives two's complement
	always_comb begin
		if (sel == adc_readout_pkg::CH_IBAT) begin
			if (current_on) begin
				coded = raw ^ adc_readout_pkg::SIGN_BIT;
			end else begin
				coded = adc_readout_pkg::CODE_ZERO;
			end
		end else begin
			coded = raw;
		end
	end
endmodule : result_coder

//--- design/adc_dedicated_channel_readout.sv
// Conversion sequencer, result slots and AXI4-Lite register slave for channels 0 to 7
`timescale 1ns/1ps
module adc_dedicated_channel_readout #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   conv_req,
	output logic [2:0]             conv_sel,
	output logic                   sample_strobe,
	input  wire logic              conv_done,
	input  wire logic [9:0]        conv_code,
	output logic                   battery_current_enable,
	output logic                   charger_divider_select,
	output logic                   busy
);
	localparam int RW = adc_readout_pkg::RES_W;
	localparam int IW = adc_readout_pkg::IDX_W;

	// Single mode on the current channel interleaves pairs; multi mode pairs slots 0 and 1
	function automatic logic is_current(input adc_readout_pkg::ctrl_t c, input logic [IW-1:0] i);
		if (c.channel_mode_select) begin
			is_current = (c.first_slot_address == adc_readout_pkg::CH_IBAT) && i[0];
		end else begin
			is_current = (i == adc_readout_pkg::CH_IBAT);
		end
	endfunction : is_current

	function automatic logic [IW-1:0] sel_of(input adc_readout_pkg::ctrl_t c, input logic [IW-1:0] i);
		if (is_current(c, i)) begin
			sel_of = adc_readout_pkg::CH_IBAT;
		end else if (c.channel_mode_select && c.first_slot_address == adc_readout_pkg::CH_IBAT) begin
			sel_of = adc_readout_pkg::CH_VBAT;
		end else if (c.channel_mode_select) begin
			sel_of = c.first_slot_address;
		end else begin
			sel_of = i;
		end
	endfunction : sel_of

	function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
		word_of = {a[ADDR_W-1:2], 2'b00};
	endfunction : word_of

	adc_readout_pkg::ctrl_t     ctrl_q, ctrl_d, run_q, run_d;
	logic                       aw_pend_q, aw_pend_d, w_pend_q, w_pend_d;
	logic [ADDR_W-1:0]          aw_addr_q, aw_addr_d;
	logic [31:0]                w_data_q, w_data_d;
	logic [3:0]                 w_strb_q, w_strb_d;
	logic                       awready_q, awready_d, wready_q, wready_d;
	logic                       bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]                 bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]                rdata_q, rdata_d;
	logic                       start_req;
	adc_readout_pkg::seq_state_t st_q, st_d;
	logic [IW-1:0]              idx_q, idx_d;
	logic [adc_readout_pkg::TICK_W-1:0] tick_q, tick_d;
	logic                       req_q, req_d, smp_q, smp_d, done_q, done_d, busy_q, busy_d;
	logic [IW-1:0]              sel_q, sel_d;
	logic [RW-1:0]              slot_q [adc_readout_pkg::SLOTS];
	logic [RW-1:0]              coded;
	logic                       store;
	logic [RW-1:0]              store_val;

	result_coder u_coder (
		.sel        (sel_q),
		.current_on (run_q.battery_current_enable),
		.raw        (conv_code),
		.coded      (coded)
	);

	// Register slave: address and data taken in either order, response once both are in
	always_comb begin
		ctrl_d    = ctrl_q;
		aw_pend_d = aw_pend_q;
		aw_addr_d = aw_addr_q;
		w_pend_d  = w_pend_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		start_req = 1'b0;
		if (s_axi_awvalid && awready_q) begin
			aw_pend_d = 1'b1;
			aw_addr_d = word_of(s_axi_awaddr);
		end
		if (s_axi_wvalid && wready_q) begin
			w_pend_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (aw_pend_q && w_pend_q && !bvalid_q) begin
			aw_pend_d = 1'b0;
			w_pend_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = adc_readout_pkg::RESP_OKAY;
			case (aw_addr_q)
				adc_readout_pkg::OFF_CTRL: begin
					if (w_strb_q[0]) begin
						ctrl_d.channel_mode_select    = w_data_q[adc_readout_pkg::CTRL_MODE];
						ctrl_d.battery_current_enable = w_data_q[adc_readout_pkg::CTRL_BEN];
						ctrl_d.charger_divider_select = w_data_q[adc_readout_pkg::CTRL_DIV];
						ctrl_d.first_slot_address     = w_data_q[adc_readout_pkg::CTRL_ADDR +: IW];
						start_req = w_data_q[adc_readout_pkg::CTRL_START];
					end
				end
				adc_readout_pkg::OFF_STATUS, adc_readout_pkg::OFF_RESULT: bresp_d = adc_readout_pkg::RESP_OKAY;
				default: bresp_d = adc_readout_pkg::RESP_SLVERR;
			endcase
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rdata_d  = '0;
			rresp_d  = adc_readout_pkg::RESP_OKAY;
			case (word_of(s_axi_araddr))
				adc_readout_pkg::OFF_CTRL: begin
					rdata_d[adc_readout_pkg::CTRL_START] = busy;
					rdata_d[adc_readout_pkg::CTRL_MODE]  = ctrl_q.channel_mode_select;
					rdata_d[adc_readout_pkg::CTRL_BEN]   = ctrl_q.battery_current_enable;
					rdata_d[adc_readout_pkg::CTRL_DIV]   = ctrl_q.charger_divider_select;
					rdata_d[adc_readout_pkg::CTRL_ADDR +: IW] = ctrl_q.first_slot_address;
				end
				adc_readout_pkg::OFF_STATUS: begin
					rdata_d[adc_readout_pkg::STAT_BUSY] = busy;
					rdata_d[adc_readout_pkg::STAT_DONE] = done_q;
				end
				adc_readout_pkg::OFF_RESULT: begin
					rdata_d[RW-1:0] = slot_q[ctrl_q.first_slot_address];
				end
				default: rresp_d = adc_readout_pkg::RESP_SLVERR;
			endcase
		end
		awready_d = !aw_pend_d && !bvalid_d;
		wready_d  = !w_pend_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	// Sequencer: one time-base tick before each of the eight slots
	always_comb begin
		st_d      = st_q;
		idx_d     = idx_q;
		tick_d    = tick_q;
		req_d     = req_q;
		smp_d     = 1'b0;
		sel_d     = sel_q;
		run_d     = run_q;
		done_d    = done_q;
		store     = 1'b0;
		store_val = coded;
		case (st_q)
			adc_readout_pkg::ST_IDLE: begin
				if (start_req) begin
					run_d  = ctrl_d;
					idx_d  = '0;
					tick_d = '0;
					done_d = 1'b0;
					st_d   = adc_readout_pkg::ST_WAIT;
				end
			end
			adc_readout_pkg::ST_WAIT: begin
				if (tick_q == adc_readout_pkg::TICK_W'(adc_readout_pkg::TICK_CYC - 1)) begin
					tick_d = '0;
					if (is_current(run_q, idx_q) && !run_q.battery_current_enable) begin
						store     = 1'b1;
						store_val = adc_readout_pkg::CODE_ZERO;
					end else begin
						req_d = 1'b1;
						sel_d = sel_of(run_q, idx_q);
						smp_d = !is_current(run_q, idx_q);
						st_d  = adc_readout_pkg::ST_CONV;
					end
				end else begin
					tick_d = tick_q + 1'b1;
				end
			end
			adc_readout_pkg::ST_CONV: begin
				if (conv_done) begin
					req_d = 1'b0;
					store = 1'b1;
					st_d  = adc_readout_pkg::ST_WAIT;
				end
			end
			default: st_d = adc_readout_pkg::ST_IDLE;
		endcase
		if (store) begin
			if (idx_q == IW'(adc_readout_pkg::SLOTS - 1)) begin
				st_d   = adc_readout_pkg::ST_IDLE;
				done_d = 1'b1;
			end else begin
				idx_d = idx_q + 1'b1;
			end
		end
		busy_d = (st_d != adc_readout_pkg::ST_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q    <= adc_readout_pkg::CTRL_RESET;
			run_q     <= adc_readout_pkg::CTRL_RESET;
			aw_pend_q <= 1'b0;
			aw_addr_q <= '0;
			w_pend_q  <= 1'b0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= adc_readout_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= adc_readout_pkg::RESP_OKAY;
			st_q      <= adc_readout_pkg::ST_IDLE;
			busy_q    <= 1'b0;
			idx_q     <= '0;
			tick_q    <= '0;
			req_q     <= 1'b0;
			smp_q     <= 1'b0;
			sel_q     <= '0;
			done_q    <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			run_q     <= run_d;
			aw_pend_q <= aw_pend_d;
			aw_addr_q <= aw_addr_d;
			w_pend_q  <= w_pend_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			st_q      <= st_d;
			busy_q    <= busy_d;
			idx_q     <= idx_d;
			tick_q    <= tick_d;
			req_q     <= req_d;
			smp_q     <= smp_d;
			sel_q     <= sel_d;
			done_q    <= done_d;
		end
	end

	// Only the sequencer writes the slots, so readout never races a bus write
	for (genvar s = 0; s < adc_readout_pkg::SLOTS; s++) begin : g_slot
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				slot_q[s] <= adc_readout_pkg::CODE_ZERO;
			end else if (store && idx_q == IW'(s)) begin
				slot_q[s] <= store_val;
			end
		end
	end

	assign s_axi_awready          = awready_q;
	assign s_axi_wready           = wready_q;
	assign s_axi_bvalid           = bvalid_q;
	assign s_axi_bresp            = bresp_q;
	assign s_axi_arready          = arready_q;
	assign s_axi_rvalid           = rvalid_q;
	assign s_axi_rdata            = rdata_q;
	assign s_axi_rresp            = rresp_q;
	assign conv_req               = req_q;
	assign conv_sel               = sel_q;
	assign sample_strobe          = smp_q;
	assign battery_current_enable = run_q.battery_current_enable;
	assign charger_divider_select = run_q.charger_divider_select;
	assign busy                   = busy_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_current_gated: assert property (conv_req && conv_sel == adc_readout_pkg::CH_IBAT
		|-> battery_current_enable) else $error("Current converted while disabled");
	a_zero_slot: assert property (store && is_current(run_q, idx_q) && !run_q.battery_current_enable
		|=> slot_q[$past(idx_q)] == adc_readout_pkg::CODE_ZERO) else $error("Disabled current slot not zero");
	a_pair_no_sample: assert property ($rose(conv_req) && conv_sel == adc_readout_pkg::CH_IBAT
		|-> !sample_strobe) else $error("Current conversion resampled");
	a_voltage_samples: assert property ($rose(conv_req) && conv_sel != adc_readout_pkg::CH_IBAT
		|-> sample_strobe) else $error("Voltage conversion without sample");
	a_single_pairs: assert property ($rose(conv_req) && run_q.channel_mode_select
		&& run_q.first_slot_address == adc_readout_pkg::CH_IBAT
		|-> conv_sel == (idx_q[0] ? adc_readout_pkg::CH_IBAT : adc_readout_pkg::CH_VBAT))
		else $error("Single mode pair order wrong");
	a_multi_slot: assert property ($rose(conv_req) && !run_q.channel_mode_select
		|-> conv_sel == idx_q) else $error("Multi mode channel not slot index");
	a_single_chan: assert property ($rose(conv_req) && run_q.channel_mode_select
		&& run_q.first_slot_address != adc_readout_pkg::CH_IBAT
		|-> conv_sel == run_q.first_slot_address) else $error("Single mode channel wrong");
	a_current_code: assert property (conv_req && conv_done && conv_sel == adc_readout_pkg::CH_IBAT
		|=> slot_q[$past(idx_q)] == ($past(conv_code) ^ adc_readout_pkg::SIGN_BIT))
		else $error("Current code not two's complement");
	a_voltage_code: assert property (conv_req && conv_done && conv_sel != adc_readout_pkg::CH_IBAT
		|=> slot_q[$past(idx_q)] == $past(conv_code)) else $error("Voltage code altered");
	a_settings_hold: assert property (busy && !$rose(busy) |-> $stable(run_q))
		else $error("Settings changed inside series");
	a_write_resp: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped before taken");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped before taken");

	c_multi_series: cover property ($fell(busy) && !run_q.channel_mode_select);
	c_single_pairs: cover property ($fell(busy) && run_q.channel_mode_select
		&& run_q.first_slot_address == adc_readout_pkg::CH_IBAT && run_q.battery_current_enable);
	c_disabled_zero: cover property ($fell(busy) && !run_q.battery_current_enable);
	c_result_read: cover property (s_axi_arvalid && arready_q
		&& word_of(s_axi_araddr) == adc_readout_pkg::OFF_RESULT);
endmodule : adc_dedicated_channel_readout

//--- testbench/adc_dedicated_channel_readout_tb.sv
// Self-checking bench: register access and conversion series of the dedicated channel readout
`timescale 1ns/1ps
module adc_dedicated_channel_readout_tb;
	logic        aclk;
	logic        aresetn;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        conv_req, sample_strobe, conv_done, battery_current_enable, charger_divider_select, busy;
	logic [2:0]  conv_sel;
	logic [9:0]  conv_code;
	int          mismatches, checked, conv_n, rsp_cnt;
	logic        prev_ben, prev_div;
	logic [31:0] d;
	logic [1:0]  r;
	logic [2:0]  sel_log [8];
	logic        strobe_log [8];
	// Full scale, zero and both sign boundaries of the current code
	logic [9:0]  codes [8] = '{10'h3ff, 10'h000, 10'h214, 10'h1ff, 10'h215, 10'h200, 10'h0a5, 10'h35a};

	adc_dedicated_channel_readout #(.ADDR_W(8)) i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .conv_req, .conv_sel, .sample_strobe, .conv_done,
		.conv_code, .battery_current_enable, .charger_divider_select, .busy);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Converter core stand-in; the code line toggles when nothing is presented
	always @(posedge aclk) begin
		conv_done <= 1'b0;
		conv_code <= ~conv_code;
		if (!conv_req)
			rsp_cnt <= 0;
		else if (rsp_cnt == 0) begin
			sel_log[conv_n[2:0]] <= conv_sel;
			strobe_log[conv_n[2:0]] <= sample_strobe;
			rsp_cnt <= 1;
		end else if (rsp_cnt == 3) begin
			conv_done <= 1'b1;
			conv_code <= codes[conv_n[2:0]];
			conv_n <= conv_n + 1;
			rsp_cnt <= 4;
		end else if (rsp_cnt < 3)
			rsp_cnt <= rsp_cnt + 1;
	end

	task automatic test_done;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic guard(input int n);
		if (n >= 4000) begin
			check("wait_bound", n, 0);
			test_done();
		end
	endtask : guard

	task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 4000; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		guard(n);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 4000; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		guard(n);
	endtask : axi_read

	function automatic logic [31:0] cw(input logic st, input logic md, input logic be, input logic dv,
		input logic [2:0] ad);
		cw = {25'h0, ad, dv, be, md, st};
	endfunction : cw

	task automatic series(input logic md, input logic be, input logic dv, input logic [2:0] ad);
		int i, k, n;
		logic [2:0] es;
		axi_write(adc_readout_pkg::OFF_CTRL, cw(1'b0, md, be, dv, ad), r);
		check("ben_held", battery_current_enable, prev_ben);
		check("div_held", charger_divider_select, prev_div);
		conv_n = 0;
		axi_write(adc_readout_pkg::OFF_CTRL, cw(1'b1, md, be, dv, ad), r);
		for (n = 0; n < 4000 && busy !== 1'b1; n++)
			@(posedge aclk);
		guard(n);
		check("ben_port", battery_current_enable, be);
		check("div_port", charger_divider_select, dv);
		// A start while busy must be ignored and must not disturb the latched settings
		axi_write(adc_readout_pkg::OFF_CTRL, cw(1'b1, md, !be, !dv, 3'h7), r);
		check("ben_busy", battery_current_enable, be);
		check("div_busy", charger_divider_select, dv);
		for (n = 0; n < 4000 && busy !== 1'b0; n++)
			@(posedge aclk);
		guard(n);
		prev_ben = be;
		prev_div = dv;
		axi_read(adc_readout_pkg::OFF_STATUS, d, r);
		check("status_done", d[1:0], 2'b10);
		k = 0;
		for (i = 0; i < 8; i++) begin
			es = md ? ((ad == 3'h1) ? {2'b00, i[0]} : ad) : i[2:0];
			axi_write(adc_readout_pkg::OFF_CTRL, cw(1'b0, md, be, dv, i[2:0]), r);
			axi_read(adc_readout_pkg::OFF_RESULT, d, r);
			if (es == adc_readout_pkg::CH_IBAT && !be)
				check("slot_off", d[9:0], adc_readout_pkg::CODE_ZERO);
			else begin
				check("conv_sel", sel_log[k], es);
				check("strobe", strobe_log[k], es != adc_readout_pkg::CH_IBAT);
				if (es == adc_readout_pkg::CH_IBAT)
					check("slot_cur", d[9:0], codes[k] ^ adc_readout_pkg::SIGN_BIT);
				else
					check("slot_volt", d[9:0], codes[k]);
				k++;
			end
		end
		check("conv_count", conv_n, k);
	endtask : series

	initial begin
		aresetn = 1'b0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		conv_done = 1'b0;
		conv_code = 10'h000;
		conv_n = 0;
		rsp_cnt = 0;
		prev_ben = 1'b0;
		prev_div = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		check("div_reset", charger_divider_select, 1'b1);
		axi_read(adc_readout_pkg::OFF_CTRL, d, r);
		check("ctrl_reset", d[6:0], 7'h08);
		axi_read(8'h0c, d, r);
		check("rresp_unmapped", r, adc_readout_pkg::RESP_SLVERR);
		check("rdata_unmapped", d, 32'h0000_0000);
		axi_write(8'h0c, 32'h0000_0000, r);
		check("bresp_unmapped", r, adc_readout_pkg::RESP_SLVERR);
		// Control write without its low byte lane enabled leaves the settings alone
		s_axi_wstrb <= 4'he;
		axi_write(adc_readout_pkg::OFF_CTRL, 32'h0000_0076, r);
		s_axi_wstrb <= 4'hf;
		check("bresp_nostrb", r, adc_readout_pkg::RESP_OKAY);
		axi_write(adc_readout_pkg::OFF_STATUS, 32'h0000_0003, r);
		check("bresp_status", r, adc_readout_pkg::RESP_OKAY);
		axi_read(adc_readout_pkg::OFF_CTRL, d, r);
		check("ctrl_nostrb", d[6:0], 7'h08);
		axi_read(adc_readout_pkg::OFF_STATUS, d, r);
		check("status_idle", d[1:0], 2'b00);
		// Multi mode with the current path off, then on; single mode on the current pair and on supply
		series(1'b0, 1'b0, 1'b1, 3'h0);
		series(1'b0, 1'b1, 1'b0, 3'h0);
		series(1'b1, 1'b1, 1'b1, 3'h1);
		series(1'b1, 1'b0, 1'b1, 3'h1);
		series(1'b1, 1'b1, 1'b0, 3'h2);
		test_done();
	end
endmodule : adc_dedicated_channel_readout_tb
